// ===== xq_lane_align.sv
// What this block does
// - entering first miss state clears good counter; four good codes regain sync
// - error in first miss state moves lane to second miss state
// - second miss: counter cleared; four good go to miss1, error to miss3
// - third miss: counter cleared; four good go to miss1, error unsyncs lane
// - error while synchronized moves lane to first miss state
// - any unsynchronized lane forces local fault columns on receive bus
// - disparity error on A, K or T marks preceding data code 0xFE
// - every detected fault sets sticky local fault status bit
// - local fault column is 9c/00/00/01 with only lane 0 control
// - received sequence sets pass untouched; the only ones generated here are local fault columns
// - each lane feeds a 32 entry, 32 bit receive fifo
// - lanes are deskewed by aligning fifo heads on alignment codes
// - column machine unaligned after reset or unsync; aligns then goes det1
// - column flag low forces local fault columns on receive bus
// - aligned state: flag high; deskew error at gap position goes fail1
// - fail states keep flag high; each missed column steps toward unaligned
// - transceiver mode replaces gap idles with alignment and comma codes
// - idles in the terminate column become comma codes
// - later idle columns: alignment first, then comma or compensation columns
// - any non-idle column returns the gap machine to sending data
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "xq_params.svh"
module xq_lane_align #(
    parameter int FIFO_W = 32,
    parameter int FIFO_D = 32
) (
    input  wire logic                   mclk_i,
    input  wire logic                   resetn_i,
    input  wire logic [11:0]            paddr_i,
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [31:0]            pwdata_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    input  wire logic                   lane_clk_i,
    input  wire xq_pkg::xq_lane_t [3:0] lane_i,
    output logic      [31:0]            rxd_o,
    output logic      [3:0]             rxc_o,
    output logic                        rx_vld_o,
    input  wire logic [31:0]            txd_i,
    input  wire logic [3:0]             txc_i,
    input  wire logic                   tx_vld_i,
    output logic      [31:0]            txd_o,
    output logic      [3:0]             txc_o,
    output logic                        tx_vld_o
);
    if (FIFO_W < 9 || FIFO_D < 4)
    begin : g_chk
        $error("fifo too small for a lane code");
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    // -------------------------------------------------
    // link input synchronisers
    // -------------------------------------------------
    logic                   lck_s1_ff, lck_s2_ff, lck_s3_ff, lstb;
    xq_pkg::xq_lane_t [3:0] lane_s1_ff, lane_s2_ff;

    // lane data is launched on the rising link edge, taken on the falling
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            lck_s1_ff  <= 1'b0;
            lck_s2_ff  <= 1'b0;
            lck_s3_ff  <= 1'b0;
            lane_s1_ff <= '0;
            lane_s2_ff <= '0;
        end
        else
        begin
            lck_s1_ff  <= lane_clk_i;
            lck_s2_ff  <= lck_s1_ff;
            lck_s3_ff  <= lck_s2_ff;
            lane_s1_ff <= lane_i;
            lane_s2_ff <= lane_s1_ff;
        end
    end

    assign lstb = lck_s3_ff & ~lck_s2_ff;

    // -------------------------------------------------
    // per-lane sync machine, error marking and fifo
    // -------------------------------------------------
    xq_pkg::xq_code_t [3:0] head;
    logic [3:0]             emp, ovf, insync, isa, pop;

    for (genvar g = 0; g < 4; g++)
    begin : g_lane
        xq_pkg::xq_lane_t li;
        xq_pkg::xq_code_t cur, wcode, prv_ff, nxt_prv;
        xq_pkg::xq_sync_t st_ff, nxt_st;
        logic [1:0]       gc_ff, nxt_gc;
        logic [FIFO_W-1:0] hw;
        logic             pv_ff, nxt_pv, bad, comma, eop, full;
        logic [2:0]       ag_ff, nxt_ag;

        // bad codes become error characters; end codes with a disparity error flag the data code before
        always_comb
        begin
            li    = lane_s2_ff[g];
            bad   = li.cerr | li.derr;
            comma = li.k & (li.d == `XQ_C_COMMA) & ~bad;
            eop   = li.k & li.derr & (li.d == `XQ_C_ALGN || li.d == `XQ_C_COMMA
                                      || li.d == `XQ_C_TERM);
            cur   = bad ? {1'b1, `XQ_C_ERR} : {li.k, li.d};
            wcode = prv_ff;
            if (eop && !prv_ff.k)
                wcode = {1'b1, `XQ_C_ERR};
            nxt_prv = lstb ? cur : prv_ff;
            nxt_pv  = pv_ff | lstb;
        end

        // lane synchronisation machine, stepped once per lane code
        always_comb
        begin
            nxt_st = st_ff;
            nxt_gc = gc_ff;
            // checker count of good codes since entering miss1
            nxt_ag = (st_ff == xq_pkg::S_MISS1) ? ag_ff + 3'(lstb & ~bad) : 3'h0;
            if (lstb)
            begin
                unique case (st_ff)
                    xq_pkg::S_UNSYNC: if (comma) nxt_st = xq_pkg::S_ACQ1;
                    xq_pkg::S_ACQ1:   if (bad) nxt_st = xq_pkg::S_UNSYNC;
                                      else if (comma) nxt_st = xq_pkg::S_ACQ2;
                    xq_pkg::S_ACQ2:   if (bad) nxt_st = xq_pkg::S_UNSYNC;
                                      else if (comma) nxt_st = xq_pkg::S_ACQ3;
                    xq_pkg::S_ACQ3:   if (bad) nxt_st = xq_pkg::S_UNSYNC;
                                      else if (comma) nxt_st = xq_pkg::S_SYNC;
                    xq_pkg::S_SYNC:   if (bad) nxt_st = xq_pkg::S_MISS1;
                    xq_pkg::S_MISS1:  if (bad) nxt_st = xq_pkg::S_MISS2;
                                      else if (gc_ff == `XQ_GOOD_LAST)
                                          nxt_st = xq_pkg::S_SYNC;
                    xq_pkg::S_MISS2:  if (bad) nxt_st = xq_pkg::S_MISS3;
                                      else if (gc_ff == `XQ_GOOD_LAST)
                                          nxt_st = xq_pkg::S_MISS1;
                    xq_pkg::S_MISS3:  if (bad) nxt_st = xq_pkg::S_UNSYNC;
                                      else if (gc_ff == `XQ_GOOD_LAST)
                                          nxt_st = xq_pkg::S_MISS1;
                endcase
                // counter restarts on every state entry
                nxt_gc = (nxt_st != st_ff) ? 2'h0 : gc_ff + 2'h1;
            end
        end

        always_ff @(posedge mclk_i or negedge resetn_i)
        begin
            if (!resetn_i)
            begin
                st_ff  <= xq_pkg::S_UNSYNC;
                gc_ff  <= 2'h0;
                prv_ff <= '0;
                pv_ff  <= 1'b0;
                ag_ff  <= 3'h0;
            end
            else
            begin
                st_ff  <= nxt_st;
                gc_ff  <= nxt_gc;
                prv_ff <= nxt_prv;
                pv_ff  <= nxt_pv;
                ag_ff  <= nxt_ag;
            end
        end

        // skew and rate absorbing fifo
        xq_lane_fifo #(
            .DW    (FIFO_W),
            .DEPTH (FIFO_D)
        ) u_fifo (
            .mclk_i   (mclk_i),
            .resetn_i (resetn_i),
            .wr_i     (lstb & pv_ff),
            .wdata_i  ({{(FIFO_W-9){1'b0}}, wcode}),
            .rd_i     (pop[g]),
            .head_o   (hw),
            .empty_o  (emp[g]),
            .full_o   (full)
        );

        assign head[g]   = hw[8:0];
        assign ovf[g]    = lstb & pv_ff & full;
        assign insync[g] = (st_ff >= xq_pkg::S_SYNC); // miss states still count as synced
        assign isa[g]    = ~emp[g] & hw[8] & (hw[7:0] == `XQ_C_ALGN);

        a_sync_to_miss: assert property (lstb && st_ff == xq_pkg::S_SYNC && bad
            |=> st_ff == xq_pkg::S_MISS1 && gc_ff == 2'h0)
            else $error("error in sync did not enter miss1");
        a_miss1_err: assert property (lstb && st_ff == xq_pkg::S_MISS1 && bad
            |=> st_ff == xq_pkg::S_MISS2)
            else $error("error in miss1 did not enter miss2");
        a_miss_good: assert property (lstb && st_ff == xq_pkg::S_MISS1 && !bad
            && ag_ff == 3'h3 |=> st_ff == xq_pkg::S_SYNC)
            else $error("four good codes did not regain sync");
        a_miss3_err: assert property (lstb && st_ff == xq_pkg::S_MISS3 && bad
            |=> st_ff == xq_pkg::S_UNSYNC)
            else $error("error in miss3 did not unsync");
        a_miss2_err: assert property (lstb && st_ff == xq_pkg::S_MISS2 && bad
            |=> st_ff == xq_pkg::S_MISS3)
            else $error("error in miss2 did not enter miss3");
    end

    // -------------------------------------------------
    // column deskew machine
    // -------------------------------------------------
    xq_pkg::xq_col_t col_ff, nxt_col;
    logic            all_sync, allv, alla, anya, colpop, badcol, dsk_err;
    logic            aligned;

    // heads step together once aligned; while unaligned each lane
    // drains until it shows an alignment code
    always_comb
    begin
        all_sync = &insync;
        allv     = ~|emp;
        alla     = allv & (&isa);
        anya     = |isa;
        colpop   = allv & (col_ff != xq_pkg::C_UNALIGN);
        badcol   = colpop & anya & ~alla;
        dsk_err  = |ovf;
        aligned  = (col_ff >= xq_pkg::C_ALIGN);
        if (col_ff == xq_pkg::C_UNALIGN)
            pop = ~emp & (~isa | {4{alla}});
        else
            pop = {4{colpop}};
        nxt_col = col_ff;
        unique case (col_ff)
            xq_pkg::C_UNALIGN: if (alla) nxt_col = xq_pkg::C_DET1;
            xq_pkg::C_DET1:    if (badcol || dsk_err) nxt_col = xq_pkg::C_UNALIGN;
                               else if (colpop && alla) nxt_col = xq_pkg::C_DET2;
            xq_pkg::C_DET2:    if (badcol || dsk_err) nxt_col = xq_pkg::C_UNALIGN;
                               else if (colpop && alla) nxt_col = xq_pkg::C_DET3;
            xq_pkg::C_DET3:    if (badcol || dsk_err) nxt_col = xq_pkg::C_UNALIGN;
                               else if (colpop && alla) nxt_col = xq_pkg::C_ALIGN;
            xq_pkg::C_ALIGN:   if (badcol || dsk_err) nxt_col = xq_pkg::C_FAIL1;
            xq_pkg::C_FAIL1:   if (colpop && alla) nxt_col = xq_pkg::C_ALIGN;
                               else if (badcol) nxt_col = xq_pkg::C_FAIL2;
            xq_pkg::C_FAIL2:   if (colpop && alla) nxt_col = xq_pkg::C_ALIGN;
                               else if (badcol) nxt_col = xq_pkg::C_FAIL3;
            xq_pkg::C_FAIL3:   if (colpop && alla) nxt_col = xq_pkg::C_ALIGN;
                               else if (badcol) nxt_col = xq_pkg::C_UNALIGN;
        endcase
        if (!all_sync)
            nxt_col = xq_pkg::C_UNALIGN;
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            col_ff <= xq_pkg::C_UNALIGN;
        else
            col_ff <= nxt_col;
    end

    a_col_unsync: assert property (!all_sync |=> col_ff == xq_pkg::C_UNALIGN)
        else $error("column machine not unaligned after lane loss");
    a_fail_back: assert property (col_ff >= xq_pkg::C_FAIL1 && colpop && alla
        && all_sync |=> col_ff == xq_pkg::C_ALIGN)
        else $error("complete column did not restore alignment");

    // -------------------------------------------------
    // receive output and fault reporting
    // -------------------------------------------------
    logic [31:0] rxd_ff, nxt_rxd;
    logic [3:0]  rxc_ff, nxt_rxc;
    logic        rxv_ff, nxt_rxv, fault;

    // data columns pass untouched, faults replace them
    always_comb
    begin
        fault   = ~all_sync | ~aligned;
        nxt_rxv = colpop | (lstb & (col_ff == xq_pkg::C_UNALIGN));
        nxt_rxd = rxd_ff;
        nxt_rxc = rxc_ff;
        if (nxt_rxv)
        begin
            if (fault)
            begin
                nxt_rxd = {`XQ_LF_TOP, `XQ_LF_MID, `XQ_LF_MID, `XQ_C_LF};
                nxt_rxc = 4'h1;
            end
            else
            begin
                nxt_rxd = {head[3].d, head[2].d, head[1].d, head[0].d};
                nxt_rxc = {head[3].k, head[2].k, head[1].k, head[0].k};
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rxd_ff <= '0;
            rxc_ff <= '0;
            rxv_ff <= 1'b0;
        end
        else
        begin
            rxd_ff <= nxt_rxd;
            rxc_ff <= nxt_rxc;
            rxv_ff <= nxt_rxv;
        end
    end

    a_lf_out: assert property (nxt_rxv && fault |=> rxv_ff && rxc_ff == 4'h1
        && rxd_ff == {`XQ_LF_TOP, `XQ_LF_MID, `XQ_LF_MID, `XQ_C_LF})
        else $error("fault did not produce a local fault column");

    // -------------------------------------------------
    // transmit gap replacement
    // -------------------------------------------------
    xq_pkg::xq_ipg_t ipg_ff, nxt_ipg;
    logic [1:0]      cc_ff, nxt_cc;
    logic [31:0]     txd_ff, nxt_txd;
    logic [3:0]      txc_ff, nxt_txc, isi;
    logic            txv_ff, anyt, ipg_en;
    logic [7:0]      fill;

    always_comb
    begin
        anyt = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            isi[i] = txc_i[i] & (txd_i[8*i +: 8] == `XQ_C_IDLE);
            anyt   = anyt | (txc_i[i] & (txd_i[8*i +: 8] == `XQ_C_TERM));
        end
    end

    // packets start on lane 0, so a terminate column is the gap start
    always_comb
    begin
        nxt_ipg = ipg_ff;
        nxt_cc  = cc_ff;
        nxt_txd = tx_vld_i ? txd_i : txd_ff; // output stands until the next column
        nxt_txc = tx_vld_i ? txc_i : txc_ff;
        fill    = `XQ_C_COMMA;
        if (tx_vld_i && ipg_en)
        begin
            if (!(&isi))
            begin
                nxt_ipg = xq_pkg::I_DATA;
                for (int i = 0; i < 4; i++)
                    if (anyt && isi[i])
                        nxt_txd[8*i +: 8] = `XQ_C_COMMA;
            end
            else
            begin
                unique case (ipg_ff)
                    xq_pkg::I_DATA:  nxt_ipg = xq_pkg::I_ALGN;
                    xq_pkg::I_ALGN:  nxt_ipg = xq_pkg::I_COMMA;
                    xq_pkg::I_COMMA: nxt_ipg = (cc_ff == `XQ_CTC_GAP) ?
                                               xq_pkg::I_CTC : xq_pkg::I_COMMA;
                    xq_pkg::I_CTC:   nxt_ipg = xq_pkg::I_COMMA;
                endcase
                nxt_cc = (nxt_ipg == xq_pkg::I_COMMA) ? cc_ff + 2'h1 : 2'h0;
                if (nxt_ipg == xq_pkg::I_ALGN)
                    fill = `XQ_C_ALGN;
                else if (nxt_ipg == xq_pkg::I_CTC)
                    fill = `XQ_C_CTC;
                nxt_txd = {4{fill}};
                nxt_txc = 4'hf;
            end
        end
        else if (tx_vld_i)
            nxt_ipg = xq_pkg::I_DATA;
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ipg_ff <= xq_pkg::I_DATA;
            cc_ff  <= 2'h0;
            txd_ff <= '0;
            txc_ff <= '0;
            txv_ff <= 1'b0;
        end
        else
        begin
            ipg_ff <= nxt_ipg;
            cc_ff  <= nxt_cc;
            txd_ff <= nxt_txd;
            txc_ff <= nxt_txc;
            txv_ff <= tx_vld_i;
        end
    end

    a_tx_first_a: assert property (tx_vld_i && ipg_en && (&isi)
        && ipg_ff == xq_pkg::I_DATA |=> txd_ff == {4{`XQ_C_ALGN}})
        else $error("gap did not open with an alignment column");
    a_tx_term_k: assert property (tx_vld_i && ipg_en && anyt && isi[3]
        |=> txd_ff[31:24] == `XQ_C_COMMA)
        else $error("idle beside terminate not replaced");

    // -------------------------------------------------
    // apb registers
    // -------------------------------------------------
    logic        ctl_ff, nxt_ctl, lf_ff, nxt_lf, rdy_ff, nxt_rdy;
    logic        err_ff, nxt_err, wr_acc, hit_c, hit_s;
    logic [31:0] prd_ff, nxt_prd;

    // answer one cycle after setup; unmapped offsets error and read zero
    always_comb
    begin
        hit_c   = (paddr_i == `XQ_CTRL_OFS);
        hit_s   = (paddr_i == `XQ_STAT_OFS);
        wr_acc  = psel_i & penable_i & rdy_ff & pwrite_i;
        nxt_rdy = psel_i & ~penable_i;
        nxt_err = nxt_rdy & ~(hit_c | hit_s);
        nxt_prd = '0;
        if (nxt_rdy && !pwrite_i && hit_c)
            nxt_prd[`XQ_CTRL_IPG] = ctl_ff;
        if (nxt_rdy && !pwrite_i && hit_s)
            nxt_prd[`XQ_STAT_LF:0] = {lf_ff, aligned, insync};
        nxt_ctl = (wr_acc && hit_c) ? pwdata_i[`XQ_CTRL_IPG] : ctl_ff;
        nxt_lf  = lf_ff;
        if (wr_acc && hit_s && pwdata_i[`XQ_STAT_LF])
            nxt_lf = 1'b0;
        if (fault)
            nxt_lf = 1'b1;
        ipg_en  = ctl_ff;
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctl_ff <= `XQ_CTRL_RST;
            lf_ff  <= 1'b0;
            rdy_ff <= 1'b0;
            err_ff <= 1'b0;
            prd_ff <= '0;
        end
        else
        begin
            ctl_ff <= nxt_ctl;
            lf_ff  <= nxt_lf;
            rdy_ff <= nxt_rdy;
            err_ff <= nxt_err;
            prd_ff <= nxt_prd;
        end
    end

    a_lf_sticky: assert property (fault || (lf_ff && !(wr_acc && hit_s
        && pwdata_i[`XQ_STAT_LF])) |=> lf_ff)
        else $error("local fault status not held");

    assign prdata_o  = prd_ff;
    assign pready_o  = rdy_ff;
    assign pslverr_o = err_ff;
    assign rxd_o     = rxd_ff;
    assign rxc_o     = rxc_ff;
    assign rx_vld_o  = rxv_ff;
    assign txd_o     = txd_ff;
    assign txc_o     = txc_ff;
    assign tx_vld_o  = txv_ff;
endmodule

// ===== xq_params.svh
`ifndef XQ_PARAMS_SVH
`define XQ_PARAMS_SVH
// register offsets (byte addresses)
`define XQ_CTRL_OFS  12'h000
`define XQ_STAT_OFS  12'h004
// field positions and reset values
`define XQ_CTRL_IPG  0
`define XQ_STAT_ALGN 4
`define XQ_STAT_LF   5
`define XQ_CTRL_RST  1'b1
// four good codes: counter runs 0..3
`define XQ_GOOD_LAST 2'h3
// one compensation column after this many comma columns
`define XQ_CTC_GAP   2'h3
// control codes
`define XQ_C_IDLE    8'h07
`define XQ_C_TERM    8'hfd
`define XQ_C_ALGN    8'h7c
`define XQ_C_COMMA   8'hbc
`define XQ_C_CTC     8'h1c
`define XQ_C_LF      8'h9c
`define XQ_C_ERR     8'hfe
`define XQ_LF_MID    8'h00
`define XQ_LF_TOP    8'h01
`endif

// ===== xq_pkg.sv
package xq_pkg;
    typedef struct packed {
        logic       k;
        logic [7:0] d;
    } xq_code_t;
    typedef struct packed {
        logic       k;
        logic [7:0] d;
        logic       cerr;
        logic       derr;
    } xq_lane_t;
    typedef enum logic [2:0] {
        S_UNSYNC, S_ACQ1, S_ACQ2, S_ACQ3, S_SYNC, S_MISS1, S_MISS2, S_MISS3
    } xq_sync_t;
    typedef enum logic [2:0] {
        C_UNALIGN, C_DET1, C_DET2, C_DET3, C_ALIGN, C_FAIL1, C_FAIL2, C_FAIL3
    } xq_col_t;
    typedef enum logic [1:0] {
        I_DATA, I_ALGN, I_COMMA, I_CTC
    } xq_ipg_t;
endpackage

// ===== xq_lane_fifo.sv
`timescale 1ns/1ps
module xq_lane_fifo #(
    parameter int DW    = 32,
    parameter int DEPTH = 32
) (
    input  wire logic          mclk_i,
    input  wire logic          resetn_i,
    input  wire logic          wr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic          rd_i,
    output logic      [DW-1:0] head_o,
    output logic               empty_o,
    output logic               full_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || DEPTH != (1 << AW))
    begin : g_chk
        $error("fifo depth must be a power of two");
    end

    logic [DW-1:0] mem [DEPTH];
    logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [AW:0]   cnt_ff, nxt_cnt;
    logic [DW-1:0] head_ff, nxt_head;
    logic          do_wr, do_rd;

    // -------------------------------------------------
    // pointers, fill level and registered head word
    // -------------------------------------------------
    // head always shows the entry at the read pointer
    always_comb
    begin
        empty_o  = (cnt_ff == '0);
        full_o   = cnt_ff[AW];
        do_wr    = wr_i & ~full_o;
        do_rd    = rd_i & ~empty_o;
        nxt_wp   = wp_ff + AW'(do_wr);
        nxt_rp   = rp_ff + AW'(do_rd);
        nxt_cnt  = cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        nxt_head = (do_wr && wp_ff == nxt_rp) ? wdata_i : mem[nxt_rp];
    end

    // storage has no reset
    always_ff @(posedge mclk_i)
    begin
        if (do_wr)
            mem[wp_ff] <= wdata_i;
    end

    // state registers
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wp_ff   <= '0;
            rp_ff   <= '0;
            cnt_ff  <= '0;
            head_ff <= '0;
        end
        else
        begin
            wp_ff   <= nxt_wp;
            rp_ff   <= nxt_rp;
            cnt_ff  <= nxt_cnt;
            head_ff <= nxt_head;
        end
    end

    assign head_o = head_ff;
endmodule

// ===== xq_mac_model.sv
`timescale 1ns/1ps
// --
// protocol device transmit side
// --
module xq_mac_model (
    input  wire logic        mclk_i,
    output logic      [31:0] txd_o = 32'h0,
    output logic      [3:0]  txc_o = 4'h0,
    output logic             tx_vld_o = 1'b0
);
    // one column held to its taking edge, then released with inverted data
    task send(input logic [35:0] col);
        @(posedge mclk_i);
        {txc_o, txd_o} <= col;
        tx_vld_o       <= 1'b1;
        @(posedge mclk_i);
        txd_o    <= ~col[31:0];
        tx_vld_o <= 1'b0;
    endtask
endmodule

// ===== xaui_lane_sync_deskew_ipg_test.sv
`timescale 1ns/1ps
`include "xq_params.svh"
// --
// bench for lane sync, deskew and gap replacement
// --
module xaui_lane_sync_deskew_ipg_test;
    logic                   mclk = 1'b0, rstn = 1'b0, lclk = 1'b0, psel = 1'b0, pen = 1'b0;
    logic                   pwr = 1'b0, prdy, perr, rxv, txv, txvo, er_d;
    logic [11:0]            pa = 12'h0;
    logic [31:0]            pwd = 32'h0, prd, rxd, txd, txdo, rd_d;
    logic [3:0]             rxc, txc, txco;
    xq_pkg::xq_lane_t [3:0] lane = '0;
    int                     err_count = 0, total_checks = 0, cyc = 0;
    // transmit columns in and expected out
    localparam logic [35:0] TI [8] = '{36'h1555555fb, 36'hf070707fd, 36'hf07070707,
                                       36'hf07070707, 36'hf07070707, 36'hf07070707,
                                       36'hf07070707, 36'h012345678};
    localparam logic [35:0] TO [8] = '{36'h1555555fb, 36'hfbcbcbcfd, 36'hf7c7c7c7c,
                                       36'hfbcbcbcbc, 36'hfbcbcbcbc, 36'hfbcbcbcbc,
                                       36'hf1c1c1c1c, 36'h012345678};
    // core clock, link clock and cycle ceiling
    always #2.5 mclk = ~mclk;
    always #24 lclk = ~lclk;
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            print_verdict;
        end
    end
    // design and partner
    xq_lane_align xq_lane_align_i (.mclk_i(mclk), .resetn_i(rstn), .paddr_i(pa), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
        .pslverr_o(perr), .lane_clk_i(lclk), .lane_i(lane), .rxd_o(rxd), .rxc_o(rxc),
        .rx_vld_o(rxv), .txd_i(txd), .txc_i(txc), .tx_vld_i(txv), .txd_o(txdo),
        .txc_o(txco), .tx_vld_o(txvo));
    xq_mac_model xq_mac_model_i (.mclk_i(mclk), .txd_o(txd), .txc_o(txc), .tx_vld_o(txv));
    // compare and count
    task chk(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error column expected %h seen %h", exp, seen);
        end
    endtask
    // apb transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic er);
        @(posedge mclk);
        {psel, pwr, pa, pwd} <= {1'b1, w, a, wd};
        @(posedge mclk);
        pen <= 1'b1;
        // pready, read data and error are taken at the rising edge itself
        @(posedge mclk);
        while (prdy !== 1'b1)
            @(posedge mclk);
        rd = prd;
        er = perr;
        {psel, pen} <= 2'b00;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] m, input logic [35:0] exp);
        apb(1'b0, a, 32'h0, rd_d, er_d);
        chk({er_d, rd_d & m}, exp);
    endtask
    // same code on all four lanes for n link codes
    task lanes(input logic [7:0] d, input logic de, input int n);
        repeat (n)
        begin
            @(posedge lclk);
            for (int i = 0; i < 4; i++)
                lane[i] <= '{k: d != 8'h33, d: d, cerr: 1'b0, derr: de};
        end
    endtask
    // wait for an output column under a bound
    task rx_wait(input logic [35:0] exp);
        int n;
        n = 0;
        while (!(rxv === 1'b1 && {rxc, rxd} === exp) && n < 2000)
        begin
            @(negedge mclk);
            n++;
        end
        chk({rxc, rxd}, exp);
    endtask
    task t_regs;
        rdchk(`XQ_CTRL_OFS, 32'hffffffff, 36'h1);
        rdchk(12'h008, 32'hffffffff, 36'h100000000);
        rdchk(`XQ_STAT_OFS, 32'hffffffff, 36'h20);
        apb(1'b1, `XQ_STAT_OFS, 32'h20, rd_d, er_d);
        rdchk(`XQ_STAT_OFS, 32'h20, 36'h20);
        rx_wait(36'h10100009c);
    endtask
    // packet start on lane 0, end, gap, data column; then replacement off
    task t_tx;
        for (int i = 0; i < 8; i++)
        begin
            xq_mac_model_i.send(TI[i]);
            @(negedge mclk);
            chk({txco, txdo}, TO[i]);
        end
        apb(1'b1, `XQ_CTRL_OFS, 32'h0, rd_d, er_d);
        xq_mac_model_i.send(TI[1]);
        @(negedge mclk);
        chk({txco, txdo}, TI[1]);
        apb(1'b1, `XQ_CTRL_OFS, 32'h1, rd_d, er_d);
    endtask
    // sync, deskew, data, then loss-of-sync walk
    task t_sync;
        lanes(`XQ_C_COMMA, 1'b0, 8);
        lanes(`XQ_C_ALGN, 1'b0, 12);
        rdchk(`XQ_STAT_OFS, 32'h1f, 36'h1f);
        lanes(8'h33, 1'b0, 2);
        rx_wait(36'h033333333);
        // lane 0 misses one alignment code: fail, then a full column restores
        @(posedge lclk);
        lane <= {{3{11'h5f0}}, 11'h0cc};
        lanes(`XQ_C_ALGN, 1'b0, 1);
        rx_wait(36'he7c7c7c33);
        rx_wait(36'hf7c7c7c7c);
        lanes(`XQ_C_COMMA, 1'b1, 1);
        lanes(`XQ_C_COMMA, 1'b0, 5);
        lanes(`XQ_C_COMMA, 1'b1, 3);
        lanes(`XQ_C_COMMA, 1'b0, 1);
        rdchk(`XQ_STAT_OFS, 32'h0f, 36'h0f);
        lanes(`XQ_C_COMMA, 1'b1, 1);
        lanes(`XQ_C_COMMA, 1'b0, 1);
        rdchk(`XQ_STAT_OFS, 32'h1f, 36'h0);
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // reset for 8 cycles, then the scenarios
    initial
    begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        t_regs;
        t_tx;
        t_sync;
        print_verdict;
    end
endmodule
